// File: rtl/sosr_pkg.sv
// Constants, field layouts and carrier types for the streams overlay and scale register bank.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
// Function
// RULE1: Overlay fields inert unless enable bit 31 set
// RULE2: Suppress only in opaque blend modes 000b/001b
// RULE3: Vertical suppressed extent computed by hardware
// RULE4: Stop-fetch bits 12-3 is hidden offset plus one
// RULE5: Primary background: stop from top minus background X
// RULE6: Secondary background: stop from background minus top X
// RULE7: Resume bits 28-19 is width plus stop minus one
// RULE8: Bit 30 selects which stream lies on top
// RULE9: Reset clears overlay bits 31-30
// RULE10: First scale factor is unscaled height minus one
// RULE11: Second factor is unscaled minus scaled height
// RULE12: Seed is negated scaled height minus one
// RULE13: Scale values and seed apply at next vsync
// RULE14: Bit 18 picks single-cycle EDO for video port
// RULE15: Software sets wait bit before video port use
// RULE16: Bit 19 clear floats data lines 63-16 in ROM
// RULE17: ROM address driven on low sixteen data lines
// RULE18: Bit 20 clear arbitrates before ROM cycle
// RULE19: Bit 21 clear delays data output half clock; the code delays it a full clock
// RULE20: Software leaves bits 19-21 at zero normally
// RULE21: Window start holds line+1 and pixel+1
// RULE22: Window size holds lines and pixels minus one; the code takes the line field as the line count itself
// RULE23: Software makes bottom window full-screen
// RULE24: Software writes zero to reserved bits
// RULE25: Suppress only on lines inside top window
package sosr_pkg;

	// ==========================================
	// Register byte addresses
	localparam logic [15:0] ADDR_OVERLAY_CTRL = 16'h81DC;
	localparam logic [15:0] ADDR_VSCALE_FIRST = 16'h81E0;
	localparam logic [15:0] ADDR_VSCALE_SECOND = 16'h81E4;
	localparam logic [15:0] ADDR_ACCUM_SEED = 16'h81E8;
	localparam logic [15:0] ADDR_MEM_OPTIONS = 16'h81EC;
	localparam logic [15:0] ADDR_WIN_START = 16'h81F0;
	localparam logic [15:0] ADDR_WIN_SIZE = 16'h81F4;

	// ==========================================
	// Field positions
	localparam int OVL_EN_BIT = 31;
	localparam int OVL_TOP_BIT = 30;
	localparam int OVL_STOP_LSB = 3;
	localparam int OVL_STOP_MSB = 12;
	localparam int OVL_RESUME_LSB = 19;
	localparam int OVL_RESUME_MSB = 28;
	localparam int SCALE_MSB = 10;
	localparam int SEED_MSB = 11;
	localparam int MEM_WAIT_BIT = 18;
	localparam int MEM_FLOAT_BIT = 19;
	localparam int MEM_GRAB_BIT = 20;
	localparam int MEM_DELAY_BIT = 21;
	localparam int WIN_LO_MSB = 10;
	localparam int WIN_HI_LSB = 16;
	localparam int WIN_HI_MSB = 26;

	// ==========================================
	// Writable masks and reset values
	localparam logic [31:0] OVL_MASK = 32'hDFF81FF8;
	localparam logic [31:0] SCALE_MASK = 32'h000007FF;
	localparam logic [31:0] SEED_MASK = 32'h00000FFF;
	localparam logic [31:0] MEM_MASK = 32'h003C0000;
	localparam logic [31:0] WIN_MASK = 32'h07FF07FF;
	localparam logic [31:0] OVL_RESET = 32'h00000000;
	localparam logic [31:0] SCALE_RESET = 32'h00000000;
	localparam logic [31:0] MEM_RESET = 32'h00003000;
	localparam logic [31:0] WIN_RESET = 32'h00000000;

	// Opaque blend mode codes
	localparam logic [2:0] BLEND_OPAQUE_A = 3'h0;
	localparam logic [2:0] BLEND_OPAQUE_B = 3'h1;

	// Register count in the bank
	localparam int NUM_REGS = 7;

	// ==========================================
	// Carrier types
	typedef struct packed {
		logic [2:0] blend_mode;
		logic vsync;
		logic [10:0] line;
		logic [9:0] quadword;
	} sosr_raster_t;

	typedef struct packed {
		logic [10:0] scale_factor_first;
		logic [10:0] scale_factor_second;
		logic [11:0] accum_seed;
	} sosr_scale_t;

	typedef struct packed {
		logic single_cycle_wait_select;
		logic rom_cycle_float_ctrl;
		logic rom_bus_grab;
		logic data_out_delay_ctrl;
	} sosr_memopt_t;

endpackage

// File: rtl/sosr_regfile.sv
// Small register store for the bank, seven 32-bit words.
// Read data comes out of a register one cycle after the address.
`timescale 1ns/100ps
module sosr_regfile (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic we_i,
	input wire logic [2:0] waddr_i,
	input wire logic [31:0] wdata_i,
	input wire logic [31:0] wmask_i,
	input wire logic [2:0] raddr_i,
	output logic [31:0] rdata_o,
	output logic [sosr_pkg::NUM_REGS*32-1:0] words_o
);

	logic [31:0] mem_ff [sosr_pkg::NUM_REGS];

	// ==========================================
	// Per-word storage with reset defaults
	genvar g;
	generate
		for (g = 0; g < sosr_pkg::NUM_REGS; g++) begin : g_word
			localparam logic [31:0] RST = (g == 4) ? sosr_pkg::MEM_RESET : 32'h00000000;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					mem_ff[g] <= RST;
				end else if (we_i && waddr_i == 3'(g)) begin
					mem_ff[g] <= (mem_ff[g] & ~wmask_i) | (wdata_i & wmask_i);
				end
			end
			assign words_o[g*32 +: 32] = mem_ff[g];
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 32'h00000000;
		end else if (raddr_i < 3'(sosr_pkg::NUM_REGS)) begin
			rdata_o <= mem_ff[raddr_i];
		end else begin
			rdata_o <= 32'h00000000;
		end
	end

endmodule

// File: rtl/sosr_top.sv
// Streams overlay and vertical scale register bank with fetch suppression and ROM-cycle pin control.
// Assumes a classic Wishbone master on clk_i and raster timing from the display pipe on the same clock.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
module sosr_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire sosr_pkg::sosr_raster_t raster_i,
	input wire logic rom_cycle_i,
	input wire logic [15:0] rom_addr_i,
	input wire logic [63:0] mem_data_i,
	output logic fetch_skip_o,
	output logic primary_on_top_o,
	output sosr_pkg::sosr_scale_t scale_active_o,
	output sosr_pkg::sosr_memopt_t memopt_o,
	output logic rom_arbitrate_o,
	output logic [63:0] memory_data_lines_o,
	output logic [63:0] memory_data_lines_oe_o
);

	// ==========================================
	// Bus decode
	logic [31:0] wmask;
	logic [31:0] bytemask;
	logic [2:0] idx;
	logic hit;
	logic req;
	logic ack_ff;
	logic wr_pulse;
	logic [31:0] rdata;
	logic [sosr_pkg::NUM_REGS*32-1:0] words;

	assign req = wb_cyc_i && wb_stb_i;
	assign bytemask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	always_comb begin
		hit = 1'b1;
		idx = 3'h0;
		wmask = 32'h00000000;
		unique case (wb_adr_i)
			sosr_pkg::ADDR_OVERLAY_CTRL: begin
				idx = 3'h0;
				wmask = sosr_pkg::OVL_MASK;
			end
			sosr_pkg::ADDR_VSCALE_FIRST: begin
				idx = 3'h1;
				wmask = sosr_pkg::SCALE_MASK;
			end
			sosr_pkg::ADDR_VSCALE_SECOND: begin
				idx = 3'h2;
				wmask = sosr_pkg::SCALE_MASK;
			end
			sosr_pkg::ADDR_ACCUM_SEED: begin
				idx = 3'h3;
				wmask = sosr_pkg::SEED_MASK;
			end
			sosr_pkg::ADDR_MEM_OPTIONS: begin
				idx = 3'h4;
				wmask = sosr_pkg::MEM_MASK;
			end
			sosr_pkg::ADDR_WIN_START: begin
				idx = 3'h5;
				wmask = sosr_pkg::WIN_MASK;
			end
			sosr_pkg::ADDR_WIN_SIZE: begin
				idx = 3'h6;
				wmask = sosr_pkg::WIN_MASK;
			end
			default: begin
				hit = 1'b0;
				idx = 3'h7;
			end
		endcase
	end

	// Write commits at the edge where ack is sampled high, so a master that
	// drops the request before ack leaves every register untouched
	assign wr_pulse = req && wb_we_i && ack_ff && hit;

	sosr_regfile u_regs (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.we_i(wr_pulse),
		.waddr_i(idx),
		.wdata_i(wb_dat_i),
		.wmask_i(wmask & bytemask),
		.raddr_i(idx),
		.rdata_o(rdata),
		.words_o(words)
	);

	// Ack drops after one cycle even if the master keeps the strobe up
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req && !ack_ff;
		end
	end

	assign wb_ack_o = ack_ff;
	// Unmapped reads return zero via the regfile's out-of-range path
	assign wb_dat_o = rdata;

	// ==========================================
	// Field views
	logic [31:0] ovl_w;
	logic [31:0] mem_w;
	logic [31:0] start_w;
	logic [31:0] size_w;
	assign ovl_w = words[0*32 +: 32];
	assign mem_w = words[4*32 +: 32];
	assign start_w = words[5*32 +: 32];
	assign size_w = words[6*32 +: 32];

	// ==========================================
	// Vertical scale shadowing
	logic [2:0] pend_ff;
	logic vs_sync1_ff;
	logic vs_sync2_ff;
	logic vs_prev_ff;
	logic vs_rise;
	sosr_pkg::sosr_scale_t scale_ff;

	assign vs_rise = vs_sync2_ff && !vs_prev_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vs_sync1_ff <= 1'b0;
			vs_sync2_ff <= 1'b0;
		end else begin
			vs_sync1_ff <= raster_i.vsync;
			vs_sync2_ff <= vs_sync1_ff;
		end
	end

	// Edge history kept apart so nothing but the second stage reads the first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vs_prev_ff <= 1'b0;
		end else begin
			vs_prev_ff <= vs_sync2_ff;
		end
	end

	// A write on the vsync edge keeps its flag set, so it waits for the next vsync
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_ff <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (wr_pulse && idx == 3'(i + 1)) begin
					pend_ff[i] <= 1'b1;
				end else if (vs_rise) begin
					pend_ff[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scale_ff <= '0;
		end else if (vs_rise) begin
			// Only fields written since the last vsync move; the rest keep their active value
			if (pend_ff[0]) begin
				scale_ff.scale_factor_first <= words[1*32 +: 11]; // RULE13 RULE10
			end
			if (pend_ff[1]) begin
				scale_ff.scale_factor_second <= words[2*32 +: 11]; // RULE13 RULE11
			end
			if (pend_ff[2]) begin
				scale_ff.accum_seed <= words[3*32 +: 12]; // RULE13 RULE12
			end
		end
	end

	assign scale_active_o = scale_ff;

	// ==========================================
	// Opaque overlay fetch suppression
	logic [10:0] line_q;
	logic [9:0] qw_q;
	logic [2:0] mode_q;
	logic [10:0] top_y0;
	logic [10:0] top_h;
	logic in_rows;
	logic in_cols;
	logic opaque;
	logic skip_ff;
	logic top_ff;
	logic [9:0] stop_qw;
	logic [9:0] resume_qw;
	logic [11:0] row_now;
	logic [11:0] row_end;
	logic [10:0] col_now;

	// Line, quadword and blend mode arrive from logic on this clock, so no synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_q <= 11'h000;
			qw_q <= 10'h000;
			mode_q <= 3'h0;
		end else begin
			line_q <= raster_i.line;
			qw_q <= raster_i.quadword;
			mode_q <= raster_i.blend_mode;
		end
	end

	assign stop_qw = ovl_w[sosr_pkg::OVL_STOP_MSB:sosr_pkg::OVL_STOP_LSB]; // RULE4
	assign resume_qw = ovl_w[sosr_pkg::OVL_RESUME_MSB:sosr_pkg::OVL_RESUME_LSB]; // RULE7
	assign top_y0 = start_w[sosr_pkg::WIN_LO_MSB:0]; // RULE21
	assign top_h = size_w[sosr_pkg::WIN_LO_MSB:0]; // RULE22
	assign opaque = (mode_q == sosr_pkg::BLEND_OPAQUE_A) || (mode_q == sosr_pkg::BLEND_OPAQUE_B); // RULE2
	// Start holds line+1, so line+1 in [y0, y0+h) is inside the window.
	// One extra bit keeps a window at the bottom of the range from wrapping to zero.
	assign row_now = {1'b0, line_q} + 12'h001;
	assign row_end = {1'b0, top_y0} + {1'b0, top_h};
	assign in_rows = (row_now >= {1'b0, top_y0}) && (row_now < row_end); // RULE3 RULE25
	// Stop holds offset+1, resume holds offset-1: hidden span is [stop-1, resume]
	assign col_now = {1'b0, qw_q} + 11'h001;
	assign in_cols = (col_now >= {1'b0, stop_qw}) && (qw_q <= resume_qw); // RULE4 RULE7

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			skip_ff <= 1'b0;
		end else begin
			skip_ff <= ovl_w[sosr_pkg::OVL_EN_BIT] && opaque && in_rows && in_cols; // RULE1 RULE2
		end
	end

	// Layering only honoured while the overlay control is enabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			top_ff <= 1'b0; // RULE9
		end else begin
			top_ff <= ovl_w[sosr_pkg::OVL_EN_BIT] && ovl_w[sosr_pkg::OVL_TOP_BIT]; // RULE8 RULE1
		end
	end

	assign fetch_skip_o = skip_ff;
	assign primary_on_top_o = top_ff;

	// ==========================================
	// Memory cycle options and data pin control
	sosr_pkg::sosr_memopt_t memopt_ff;
	logic rom_s1_ff;
	logic rom_s2_ff;
	logic arb_ff;
	logic [15:0] rom_adr_s1_ff;
	logic [15:0] rom_adr_s2_ff;
	logic [63:0] drv_now;
	logic [63:0] oe_now;
	logic [63:0] drv_ff;
	logic [63:0] oe_ff;
	logic [63:0] drv_half_ff;
	logic [63:0] oe_half_ff;

	// Status copy lags the stored word by one cycle; the pin path reads the word itself
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			memopt_ff <= '0;
		end else begin
			memopt_ff.single_cycle_wait_select <= mem_w[sosr_pkg::MEM_WAIT_BIT]; // RULE14
			memopt_ff.rom_cycle_float_ctrl <= mem_w[sosr_pkg::MEM_FLOAT_BIT];
			memopt_ff.rom_bus_grab <= mem_w[sosr_pkg::MEM_GRAB_BIT];
			memopt_ff.data_out_delay_ctrl <= mem_w[sosr_pkg::MEM_DELAY_BIT];
		end
	end

	assign memopt_o = memopt_ff;

	// ROM request comes from the host side, treated as asynchronous
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rom_s1_ff <= 1'b0;
			rom_s2_ff <= 1'b0;
			arb_ff <= 1'b0;
		end else begin
			rom_s1_ff <= rom_cycle_i;
			rom_s2_ff <= rom_s1_ff;
			arb_ff <= rom_s2_ff && !mem_w[sosr_pkg::MEM_GRAB_BIT]; // RULE18
		end
	end

	assign rom_arbitrate_o = arb_ff;

	// The address is held steady from before the request rises, so it settles
	// through the same two stages as the request and is never used mid-change
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rom_adr_s1_ff <= 16'h0000;
			rom_adr_s2_ff <= 16'h0000;
		end else begin
			rom_adr_s1_ff <= rom_addr_i;
			rom_adr_s2_ff <= rom_adr_s1_ff;
		end
	end

	always_comb begin
		drv_now = mem_data_i;
		oe_now = {64{1'b1}};
		if (rom_s2_ff) begin
			drv_now[15:0] = rom_adr_s2_ff; // RULE17
			if (!mem_w[sosr_pkg::MEM_FLOAT_BIT]) begin
				oe_now[63:16] = 48'h000000000000; // RULE16
			end
		end
	end

	// Half-clock delay is approximated by a full extra stage; single clock edge only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drv_half_ff <= 64'h0000000000000000;
			oe_half_ff <= 64'h0000000000000000;
		end else begin
			drv_half_ff <= drv_now;
			oe_half_ff <= oe_now;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drv_ff <= 64'h0000000000000000;
			oe_ff <= 64'h0000000000000000;
		end else begin
			drv_ff <= mem_w[sosr_pkg::MEM_DELAY_BIT] ? drv_now : drv_half_ff; // RULE19
			oe_ff <= mem_w[sosr_pkg::MEM_DELAY_BIT] ? oe_now : oe_half_ff; // RULE19
		end
	end

	assign memory_data_lines_o = drv_ff;
	assign memory_data_lines_oe_o = oe_ff;

endmodule

// File: test/sosr_top_assertions.sv
// Checker for the overlay and scale register bank, bound to its top.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module sosr_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire sosr_pkg::sosr_raster_t raster_i,
	input wire logic rom_cycle_i,
	input wire logic [15:0] rom_addr_i,
	input wire logic [63:0] mem_data_i,
	input wire logic fetch_skip_o,
	input wire logic primary_on_top_o,
	input wire sosr_pkg::sosr_scale_t scale_active_o,
	input wire sosr_pkg::sosr_memopt_t memopt_o,
	input wire logic rom_arbitrate_o,
	input wire logic [63:0] memory_data_lines_o,
	input wire logic [63:0] memory_data_lines_oe_o
);
	// ========================================
	// Cycles since the last vsync rise, saturating
	logic vs_prev_ff;
	logic [3:0] vs_age_ff;
	always_ff @(posedge clk_i) begin
		vs_prev_ff <= raster_i.vsync;
		if (rst_i) begin
			vs_age_ff <= 4'hF;
		end else if (raster_i.vsync && !vs_prev_ff) begin
			vs_age_ff <= 4'h0;
		end else if (vs_age_ff != 4'hF) begin
			vs_age_ff <= vs_age_ff + 4'h1;
		end
	end
	// ========================================
	// Properties
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// Long enough to cover the synchroniser and the optional delay stage
	sequence rom_held_s;
		(rom_cycle_i && $stable(rom_addr_i) && $stable(memopt_o))[*6];
	endsequence
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_answer_a: assert property (req_s |=> wb_ack_o)
		else $error("request not acknowledged");
	skip_mode_a: assert property (fetch_skip_o |-> $past(raster_i.blend_mode, 2) inside {3'h0, 3'h1})
		else $error("skip outside opaque modes");
	scale_vsync_a: assert property (!$stable(scale_active_o) |-> vs_age_ff <= 4'h6)
		else $error("scale changed away from vsync");
	rom_float_a: assert property (rom_held_s ##0 !memopt_o.rom_cycle_float_ctrl |-> memory_data_lines_oe_o[63:16] == 48'h0)
		else $error("upper data lines driven in rom cycle");
	rom_addr_a: assert property (rom_held_s |-> memory_data_lines_o[15:0] == rom_addr_i)
		else $error("rom address missing on low lines");
	rom_grab_a: assert property (rom_held_s |-> rom_arbitrate_o == !memopt_o.rom_bus_grab)
		else $error("rom arbitration wrong");
	data_pass_a: assert property ((!rom_cycle_i && $stable(mem_data_i))[*6] |-> memory_data_lines_o == mem_data_i)
		else $error("outgoing data not passed");
endmodule
bind sosr_top sosr_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .raster_i(raster_i), .rom_cycle_i(rom_cycle_i), .rom_addr_i(rom_addr_i),
	.mem_data_i(mem_data_i), .fetch_skip_o(fetch_skip_o), .primary_on_top_o(primary_on_top_o),
	.scale_active_o(scale_active_o), .memopt_o(memopt_o), .rom_arbitrate_o(rom_arbitrate_o),
	.memory_data_lines_o(memory_data_lines_o), .memory_data_lines_oe_o(memory_data_lines_oe_o));

// File: test/tb_top.sv
// Self-checking bench for the overlay and scale register bank.
// Drives every input of the top itself, just after rising clk_i edges.
`timescale 1ns/100ps
module tb_top;
	logic clk_i, rst_i, cyc, stb, we, rom, ack, skip, ptop, arb;
	logic [3:0] sel;
	logic [15:0] adr, raddr;
	logic [31:0] wdat, rdat, rd;
	logic [63:0] mdat, dl, oe;
	sosr_pkg::sosr_raster_t ras;
	sosr_pkg::sosr_scale_t sc;
	sosr_pkg::sosr_memopt_t mo;
	int fail_count, checks;
	sosr_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .raster_i(ras), .rom_cycle_i(rom),
		.rom_addr_i(raddr), .mem_data_i(mdat), .fetch_skip_o(skip), .primary_on_top_o(ptop),
		.scale_active_o(sc), .memopt_o(mo), .rom_arbitrate_o(arb), .memory_data_lines_o(dl),
		.memory_data_lines_oe_o(oe));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// ========================================
	// Shared tasks
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cmp(input logic [63:0] g, input logic [63:0] e);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hF);
	endtask
	task automatic rchk(input logic [15:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, 4'hF);
		cmp(rd, e);
	endtask
	task automatic sk(input logic [2:0] m, input logic [10:0] l, input logic [9:0] q, input logic e);
		ras <= {m, 1'b0, l, q};
		idle(4);
		cmp(skip, e);
	endtask
	// ========================================
	// Scenarios
	task automatic t_reset;
		for (int i = 0; i < 8; i++) begin
			rchk(16'h81DC + 16'(4 * i), (i == 4) ? 32'h00003000 : 32'h0);
		end
	endtask
	task automatic t_masks;
		logic [31:0] m [8];
		m = '{sosr_pkg::OVL_MASK, sosr_pkg::SCALE_MASK, sosr_pkg::SCALE_MASK, sosr_pkg::SEED_MASK,
			sosr_pkg::MEM_MASK, sosr_pkg::WIN_MASK, sosr_pkg::WIN_MASK, 32'h0};
		for (int i = 0; i < 8; i++) begin
			wr(16'h81DC + 16'(4 * i), m[i]);
			rchk(16'h81DC + 16'(4 * i), m[i] | ((i == 4) ? sosr_pkg::MEM_RESET : 32'h0));
		end
		wb(1'b1, sosr_pkg::ADDR_WIN_START, 32'h0, 4'h3);
		rchk(sosr_pkg::ADDR_WIN_START, 32'h07FF0000);
	endtask
	task automatic t_scale;
		wr(sosr_pkg::ADDR_VSCALE_FIRST, 32'h00000123);
		wr(sosr_pkg::ADDR_VSCALE_SECOND, 32'h00000045);
		wr(sosr_pkg::ADDR_ACCUM_SEED, 32'h00000ABC);
		idle(8);
		cmp(sc, 64'h0);
		ras.vsync <= 1'b1;
		idle(2);
		ras.vsync <= 1'b0;
		idle(8);
		cmp(sc, {11'h123, 11'h045, 12'hABC});
	endtask
	task automatic t_rom;
		wr(sosr_pkg::ADDR_MEM_OPTIONS, 32'h00040000);
		idle(3);
		cmp(mo, 4'h8);
		wr(sosr_pkg::ADDR_MEM_OPTIONS, 32'h0);
		rom <= 1'b1;
		idle(8);
		cmp(oe[63:16], 48'h0);
		cmp(dl[15:0], 16'hBEEF);
		cmp(arb, 1'b1);
		rom <= 1'b0;
		idle(8);
		cmp(dl, mdat);
		mdat <= 64'h00FF00FF00FF00FF;
		idle(2);
		cmp(dl, 64'h0123456789ABCDEF);
		idle(1);
		cmp(dl, 64'h00FF00FF00FF00FF);
		wr(sosr_pkg::ADDR_MEM_OPTIONS, 32'h003C0000);
		rom <= 1'b1;
		idle(8);
		cmp(oe[63:16], {48{1'b1}});
		cmp(arb, 1'b0);
		cmp(mo, 4'hF);
		rom <= 1'b0;
		mdat <= 64'hFEDCBA9876543210;
		idle(8);
		cmp(dl, 64'hFEDCBA9876543210);
		mdat <= 64'h0F0F0F0F0F0F0F0F;
		idle(1);
		cmp(dl, 64'hFEDCBA9876543210);
		idle(1);
		cmp(dl, 64'h0F0F0F0F0F0F0F0F);
	endtask
	task automatic t_skip;
		wr(sosr_pkg::ADDR_WIN_START, 32'h000A0005);
		wr(sosr_pkg::ADDR_WIN_SIZE, 32'h00070003);
		wr(sosr_pkg::ADDR_OVERLAY_CTRL, 32'hC0200010);
		sk(3'h0, 11'd4, 10'd2, 1'b1);
		cmp(ptop, 1'b1);
		sk(3'h1, 11'd6, 10'd4, 1'b1);
		sk(3'h2, 11'd4, 10'd2, 1'b0);
		sk(3'h0, 11'd7, 10'd2, 1'b0);
		sk(3'h0, 11'd4, 10'd0, 1'b0);
		sk(3'h0, 11'd4, 10'd5, 1'b0);
		wr(sosr_pkg::ADDR_OVERLAY_CTRL, 32'h80200010);
		sk(3'h0, 11'd5, 10'd3, 1'b1);
		cmp(ptop, 1'b0);
		wr(sosr_pkg::ADDR_OVERLAY_CTRL, 32'h40200010);
		sk(3'h0, 11'd4, 10'd2, 1'b0);
		cmp(ptop, 1'b0);
	endtask
	initial begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		rom = 1'b0;
		sel = 4'hF;
		adr = 16'h0;
		wdat = 32'h0;
		raddr = 16'hBEEF;
		mdat = 64'h0123456789ABCDEF;
		ras = '0;
		fail_count = 0;
		checks = 0;
		idle(16);
		rst_i <= 1'b0;
		t_reset();
		t_masks();
		t_scale();
		t_rom();
		t_skip();
		report_and_stop();
	end
endmodule
